// *** verilog/flr_pkg.sv ***
// Constants and types shared by the lockout recovery test port and its erase timer.
`default_nettype none
package flr_pkg;
  localparam int unsigned IR_W = 4;
  localparam int unsigned DR_W = 7;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned PRESC_BIT = 6;
  localparam int unsigned DIV_MSB = 5;
  localparam logic [IR_W-1:0] IR_RECOVERY = 4'hB;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [DR_W-1:0] DIVIDER_RST = 7'h00;
  localparam logic [11:0] OFS_DIVIDER = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_KEY = 12'h00C;
  localparam int unsigned ST_SECURE = 0;
  localparam int unsigned ST_ERASING = 1;
  localparam int unsigned ST_DONE = 2;
  localparam int unsigned ST_ARMED = 3;
  localparam int unsigned CTRL_KEY_EN = 0;
  localparam int unsigned PIN_TCK = 0;
  localparam int unsigned PIN_TMS = 1;
  localparam int unsigned PIN_TDI = 2;
  localparam int unsigned PIN_TRST_N = 3;
  localparam logic [3:0] PIN_RST = 4'h2;
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam int unsigned TICK_W = 16;
  localparam logic [TICK_W-1:0] ERASE_TICKS_DEF = 16'h03E8;
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_RTI = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } flr_tap_t;
endpackage
`default_nettype wire

// *** verilog/flr_tmr_if.sv ***
// Link between the recovery controller and the erase timer.
`default_nettype none
interface flr_tmr_if;
  logic start;
  logic prescale_by_eight;
  logic [flr_pkg::DIV_W-1:0] div;
  logic busy;
  logic done;
  modport ctl (output start, output prescale_by_eight, output div, input busy, input done);
  modport tmr (input start, input prescale_by_eight, input div, output busy, output done);
endinterface
`default_nettype wire

// *** verilog/flr_erase_timer.sv ***
// Erase timing clock divider and mass erase duration counter.
`default_nettype none
module flr_erase_timer #(
  parameter logic [flr_pkg::TICK_W-1:0] ERASE_TICKS = flr_pkg::ERASE_TICKS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  flr_tmr_if.tmr bus
);
  logic half_r;
  logic [2:0] pre_r;
  logic [flr_pkg::DIV_W-1:0] dcnt_r;
  logic [flr_pkg::TICK_W-1:0] ticks_r;
  logic busy_r;
  logic done_r;
  logic en_in;
  logic tick;

  // The flash input clock is the system clock over two; the optional prescale adds a further eight.
  assign en_in = bus.prescale_by_eight ? (half_r && pre_r == flr_pkg::PRE8_LAST) : half_r;
  assign tick = busy_r && en_in && dcnt_r == bus.div;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r <= 1'b0;
      pre_r <= 3'h0;
    end else begin
      half_r <= ~half_r;
      if (half_r) begin
        pre_r <= pre_r + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt_r <= 6'h00;
    end else if (!busy_r) begin
      dcnt_r <= 6'h00;
    end else if (en_in) begin
      dcnt_r <= (dcnt_r == bus.div) ? 6'h00 : dcnt_r + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ticks_r <= 16'h0000;
    end else begin
      done_r <= 1'b0;
      if (bus.start && !busy_r) begin
        busy_r <= 1'b1;
        ticks_r <= 16'h0000;
      end else if (tick) begin
        ticks_r <= ticks_r + 16'h0001;
        if (ticks_r == ERASE_TICKS - 16'h0001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign bus.busy = busy_r;
  assign bus.done = done_r;

  property p_timer_start;
    @(posedge pclk) disable iff (!presetn) bus.start && !busy_r |=> busy_r && ticks_r == 16'h0000;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("Erase timer did not start.");

  property p_done_ends_busy;
    @(posedge pclk) disable iff (!presetn) $rose(done_r) |-> $fell(busy_r) && ticks_r == ERASE_TICKS;
  endproperty
  a_done_ends_busy: assert property (p_done_ends_busy) else $error("Erase ended at wrong count.");
endmodule
`default_nettype wire

// *** verilog/flr_recovery_tap.sv ***
// Flash lockout recovery test port with APB register slave and security state.
// Functional notes
// - A recovery run mass-erases all flash and thereby drops flash security.
// - The recovery instruction selects a seven-bit divider data register.
// - During recovery the test-port divider replaces the software flash divider.
// - Bit 6 drives divide-by-eight prescale, bits 5..0 the divide field.
// - After data update, entering Run-Test/Idle starts the erase.
// - Backdoor key unsecures only while backdoor key enable is set.
// - Debug read disable is loaded at reset from the flash security bytes.
//
// Design decisions made here: the APB slave port and the register offsets.
`default_nettype none
module flr_recovery_tap #(
  parameter logic [flr_pkg::TICK_W-1:0] ERASE_TICKS = flr_pkg::ERASE_TICKS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic flash_secure_in,
  input wire logic [31:0] backdoor_key_in,
  output logic flash_mass_erase,
  output logic [flr_pkg::DR_W-1:0] erase_timing_divider_value,
  output logic debug_read_disable,
  output logic recovery_done
);
  logic [3:0] s1_r, s2_r, s3_r, pin_r, pin_in;
  logic tck_prev_r;
  logic tck_rise, tck_fall, tap_rst;
  flr_pkg::flr_tap_t tap_r, tap_nxt;
  logic [flr_pkg::IR_W-1:0] ir_r, ir_sh_r;
  logic [flr_pkg::DR_W-1:0] dr_r, dr_sh_r;
  logic byp_r, armed_r, started_r, rec_active_r, start_r;
  logic [flr_pkg::DR_W-1:0] divider_r, div_eff_r;
  logic key_en_r, secure_r, cap_pending_r, done_r, dbg_r, tdo_r, tdo_oe_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, mapped, apb_wr, key_unlock;
  flr_tmr_if tmr ();

  assign pin_in = {trst_n, tdi, tms, tck};

  // Pins are asynchronous to pclk; a level is accepted only once the last two stages agree.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i] <= flr_pkg::PIN_RST[i];
          s2_r[i] <= flr_pkg::PIN_RST[i];
          s3_r[i] <= flr_pkg::PIN_RST[i];
          pin_r[i] <= flr_pkg::PIN_RST[i];
        end else begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            pin_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= pin_r[flr_pkg::PIN_TCK];
    end
  end

  assign tck_rise = pin_r[flr_pkg::PIN_TCK] && !tck_prev_r;
  assign tck_fall = !pin_r[flr_pkg::PIN_TCK] && tck_prev_r;
  assign tap_rst = !pin_r[flr_pkg::PIN_TRST_N];

  always_comb begin
    tap_nxt = tap_r;
    unique case (tap_r)
      flr_pkg::TAP_RESET: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_RESET : flr_pkg::TAP_RTI;
      flr_pkg::TAP_RTI: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_SEL_DR : flr_pkg::TAP_RTI;
      flr_pkg::TAP_SEL_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_SEL_IR : flr_pkg::TAP_CAP_DR;
      flr_pkg::TAP_CAP_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_EX1_DR : flr_pkg::TAP_SH_DR;
      flr_pkg::TAP_SH_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_EX1_DR : flr_pkg::TAP_SH_DR;
      flr_pkg::TAP_EX1_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_UPD_DR : flr_pkg::TAP_PAU_DR;
      flr_pkg::TAP_PAU_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_EX2_DR : flr_pkg::TAP_PAU_DR;
      flr_pkg::TAP_EX2_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_UPD_DR : flr_pkg::TAP_SH_DR;
      flr_pkg::TAP_UPD_DR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_SEL_DR : flr_pkg::TAP_RTI;
      flr_pkg::TAP_SEL_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_RESET : flr_pkg::TAP_CAP_IR;
      flr_pkg::TAP_CAP_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_EX1_IR : flr_pkg::TAP_SH_IR;
      flr_pkg::TAP_SH_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_EX1_IR : flr_pkg::TAP_SH_IR;
      flr_pkg::TAP_EX1_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_UPD_IR : flr_pkg::TAP_PAU_IR;
      flr_pkg::TAP_PAU_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_EX2_IR : flr_pkg::TAP_PAU_IR;
      flr_pkg::TAP_EX2_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_UPD_IR : flr_pkg::TAP_SH_IR;
      flr_pkg::TAP_UPD_IR: tap_nxt = pin_r[flr_pkg::PIN_TMS] ? flr_pkg::TAP_SEL_DR : flr_pkg::TAP_RTI;
      default: tap_nxt = flr_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_r <= flr_pkg::TAP_RESET;
    end else if (tap_rst) begin
      tap_r <= flr_pkg::TAP_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_sh_r <= flr_pkg::IR_CAPTURE;
      ir_r <= flr_pkg::IR_BYPASS;
    end else if (tap_rst || tap_r == flr_pkg::TAP_RESET) begin
      ir_r <= flr_pkg::IR_BYPASS;
    end else if (tck_rise) begin
      if (tap_r == flr_pkg::TAP_CAP_IR) begin
        ir_sh_r <= flr_pkg::IR_CAPTURE;
      end else if (tap_r == flr_pkg::TAP_SH_IR) begin
        ir_sh_r <= {pin_r[flr_pkg::PIN_TDI], ir_sh_r[flr_pkg::IR_W-1:1]};
      end else if (tap_r == flr_pkg::TAP_UPD_IR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // The divider register sits in the scan path only while the recovery instruction is current.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_sh_r <= flr_pkg::DIVIDER_RST;
      dr_r <= flr_pkg::DIVIDER_RST;
      byp_r <= 1'b0;
    end else if (tck_rise) begin
      if (ir_r == flr_pkg::IR_RECOVERY) begin
        if (tap_r == flr_pkg::TAP_CAP_DR) begin
          dr_sh_r <= dr_r;
        end else if (tap_r == flr_pkg::TAP_SH_DR) begin
          dr_sh_r <= {pin_r[flr_pkg::PIN_TDI], dr_sh_r[flr_pkg::DR_W-1:1]};
        end else if (tap_r == flr_pkg::TAP_UPD_DR) begin
          dr_r <= dr_sh_r;
        end
      end else if (tap_r == flr_pkg::TAP_CAP_DR) begin
        byp_r <= 1'b0;
      end else if (tap_r == flr_pkg::TAP_SH_DR) begin
        byp_r <= pin_r[flr_pkg::PIN_TDI];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= tap_r == flr_pkg::TAP_SH_IR || tap_r == flr_pkg::TAP_SH_DR;
      if (tap_r == flr_pkg::TAP_SH_IR) begin
        tdo_r <= ir_sh_r[0];
      end else if (ir_r == flr_pkg::IR_RECOVERY) begin
        tdo_r <= dr_sh_r[0];
      end else begin
        tdo_r <= byp_r;
      end
    end
  end

  // Arming needs a data update under the recovery instruction; the value itself is the host's duty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
      started_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (tap_rst || tap_r == flr_pkg::TAP_RESET) begin
        armed_r <= 1'b0;
        started_r <= 1'b0;
      end else if (tck_rise && tap_r == flr_pkg::TAP_UPD_DR && ir_r == flr_pkg::IR_RECOVERY) begin
        armed_r <= 1'b1;
      end else if (armed_r && !started_r && tap_r == flr_pkg::TAP_RTI) begin
        started_r <= 1'b1;
        start_r <= 1'b1;
      end
    end
  end

  // Once started the erase runs to its end; leaving Run-Test/Idle early is not defended against.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_active_r <= 1'b0;
      div_eff_r <= flr_pkg::DIVIDER_RST;
    end else begin
      if (start_r) begin
        rec_active_r <= 1'b1;
      end else if (tmr.done) begin
        rec_active_r <= 1'b0;
      end
      div_eff_r <= (rec_active_r || start_r) ? dr_r : divider_r;
    end
  end

  assign tmr.start = start_r;
  assign tmr.prescale_by_eight = div_eff_r[flr_pkg::PRESC_BIT];
  assign tmr.div = div_eff_r[flr_pkg::DIV_MSB:0];

  flr_erase_timer #(.ERASE_TICKS(ERASE_TICKS)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .bus(tmr)
  );

  assign mapped = paddr == flr_pkg::OFS_DIVIDER || paddr == flr_pkg::OFS_STATUS ||
                  paddr == flr_pkg::OFS_CTRL || paddr == flr_pkg::OFS_KEY;
  assign apb_wr = psel && penable && pready_r && pwrite && mapped;
  assign key_unlock = apb_wr && paddr == flr_pkg::OFS_KEY && key_en_r && pwdata == backdoor_key_in;

  // Security is caught one cycle after reset release, since an async reset may only load constants.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_pending_r <= 1'b1;
      secure_r <= 1'b1;
      done_r <= 1'b0;
      dbg_r <= 1'b1;
    end else begin
      cap_pending_r <= 1'b0;
      if (cap_pending_r) begin
        secure_r <= flash_secure_in;
      end else if (tmr.done || key_unlock) begin
        secure_r <= 1'b0;
      end
      if (tmr.done) begin
        done_r <= 1'b1;
      end
      dbg_r <= cap_pending_r ? flash_secure_in : (secure_r && !tmr.done && !key_unlock);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_r <= flr_pkg::DIVIDER_RST;
      key_en_r <= 1'b0;
    end else if (apb_wr && paddr == flr_pkg::OFS_DIVIDER) begin
      divider_r <= pwdata[flr_pkg::DR_W-1:0];
    end else if (apb_wr && paddr == flr_pkg::OFS_CTRL) begin
      key_en_r <= pwdata[flr_pkg::CTRL_KEY_EN];
    end
  end

  // Zero wait states: the setup cycle prepares the answer and the access cycle completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      prdata_r <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          flr_pkg::OFS_DIVIDER: prdata_r[flr_pkg::DR_W-1:0] <= divider_r;
          flr_pkg::OFS_STATUS: prdata_r[3:0] <= {armed_r, done_r, tmr.busy, secure_r};
          flr_pkg::OFS_CTRL: prdata_r[flr_pkg::CTRL_KEY_EN] <= key_en_r;
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;
  assign flash_mass_erase = rec_active_r;
  assign erase_timing_divider_value = div_eff_r;
  assign debug_read_disable = dbg_r;
  assign recovery_done = done_r;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_launch;
    start_r ##1 rec_active_r;
  endsequence

  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn) s_setup |=> pready_r;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB access not answered.");

  property p_start_in_idle;
    @(posedge pclk) disable iff (!presetn) start_r |-> $past(tap_r == flr_pkg::TAP_RTI) && armed_r;
  endproperty
  a_start_in_idle: assert property (p_start_in_idle) else $error("Erase started outside Run-Test/Idle.");

  property p_erase_runs;
    @(posedge pclk) disable iff (!presetn) s_launch |-> tmr.busy && flash_mass_erase;
  endproperty
  a_erase_runs: assert property (p_erase_runs) else $error("Mass erase not driven.");

  property p_override;
    @(posedge pclk) disable iff (!presetn) s_launch ##1 rec_active_r |-> div_eff_r == $past(dr_r);
  endproperty
  a_override: assert property (p_override) else $error("Recovery divider not applied.");

  property p_field_map;
    @(posedge pclk) disable iff (!presetn) rec_active_r |->
      tmr.prescale_by_eight == dr_r[flr_pkg::PRESC_BIT] && tmr.div == dr_r[flr_pkg::DIV_MSB:0];
  endproperty
  a_field_map: assert property (p_field_map) else $error("Divider fields misplaced.");

  property p_done_unsecures;
    @(posedge pclk) disable iff (!presetn) tmr.done && !cap_pending_r |=> !secure_r && recovery_done ##1 !dbg_r;
  endproperty
  a_done_unsecures: assert property (p_done_unsecures) else $error("Erase did not clear security.");

  property p_key_needs_enable;
    @(posedge pclk) disable iff (!presetn)
      $fell(secure_r) && !$past(tmr.done) && !$past(cap_pending_r) |-> $past(key_en_r);
  endproperty
  a_key_needs_enable: assert property (p_key_needs_enable) else $error("Key unlocked while disabled.");

  property p_capture;
    @(posedge pclk) disable iff (!presetn) cap_pending_r |=> secure_r == $past(flash_secure_in) ##1
      debug_read_disable == $past(secure_r, 1);
  endproperty
  a_capture: assert property (p_capture) else $error("Security not caught at reset.");
endmodule
`default_nettype wire

// *** testbench/flr_jtag_host.sv ***
// Debug host model that walks the test port through the lockout recovery sequence.
`default_nettype none
module flr_jtag_host (
  input wire logic pclk,
  input wire logic tdo,
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  output var logic trst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h0;
  end
  // Each phase lasts 8 pclk so the synchronised port sees every level twice over.
  // Data out is taken at the rising test clock, once the port has answered the previous fall.
  task automatic tick(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge pclk);
    q = tdo;
    tck <= 1'h1;
    repeat (8) @(posedge pclk);
    tck <= 1'h0;
  endtask
  task automatic scan(input logic ir, input int n, input logic [7:0] v, output logic [7:0] cap);
    logic q;
    cap = 8'h00;
    tick(1'h1, 1'h0, q);
    if (ir) tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
    tick(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++) tick(i == n - 1, v[i], cap[i]);
    tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
  endtask
  task automatic port_reset();
    logic q;
    trst_n <= 1'h0;
    repeat (10) @(posedge pclk);
    trst_n <= 1'h1;
    repeat (10) @(posedge pclk);
    repeat (5) tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
  endtask
  // No completion pin is watched, so the host simply idles for a generous count.
  task automatic rti_wait(input int n);
    logic q;
    repeat (n) tick(1'h0, 1'h0, q);
  endtask
  task automatic recover(input logic [6:0] div, output logic [7:0] irc);
    logic [7:0] c;
    scan(1'h1, 4, {4'h0, flr_pkg::IR_RECOVERY}, irc);
    scan(1'h0, 7, {1'h0, div}, c);
    rti_wait(120);
  endtask
endmodule
`default_nettype wire

// *** testbench/flr_recovery_tap_tb_top.sv ***
// Self-checking bench for the lockout recovery test port.
`default_nettype none
module flr_recovery_tap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ETK = 16'h0004;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic flash_secure_in, flash_mass_erase, debug_read_disable, recovery_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, backdoor_key_in;
  logic [6:0] erase_timing_divider_value, seen_div;
  logic [31:0] seed = 32'h0000419C;
  int n_fail = 0;
  int num_checks = 0;
  int erase_len = 0;
  int oe_cnt = 0;
  always #12.5 pclk = ~pclk;
  flr_recovery_tap #(.ERASE_TICKS(ETK)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .flash_secure_in,
    .backdoor_key_in, .flash_mass_erase, .erase_timing_divider_value, .debug_read_disable, .recovery_done);
  flr_jtag_host host (.pclk, .tdo, .tck, .tms, .tdi, .trst_n);
  always @(posedge pclk) begin
    if (tdo_oe === 1'h1) begin
      oe_cnt <= oe_cnt + 1;
    end
    if (flash_mass_erase === 1'h1) begin
      erase_len <= erase_len + 1;
      seen_div <= erase_timing_divider_value;
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int tick_len(input logic [6:0] v);
    return 2 * (v[6] ? 8 : 1) * (int'(v[5:0]) + 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k == 20) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic key_try(input logic [31:0] k, input logic exp_sec);
    logic [31:0] r;
    logic e;
    apb(1'h1, flr_pkg::OFS_KEY, k, r, e);
    apb(1'h0, flr_pkg::OFS_STATUS, 32'h0, r, e);
    chk("secure after key", {31'h0, exp_sec}, {31'h0, r[flr_pkg::ST_SECURE]});
  endtask
  task automatic do_reset(input logic sec);
    flash_secure_in <= sec;
    presetn <= 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done();
  end
  initial begin
    logic [31:0] r, w, key;
    logic e;
    logic [7:0] irc, c;
    logic [6:0] v;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    flash_secure_in = 1'h1;
    key = rnd();
    backdoor_key_in = key;
    do_reset(1'h1);
    chk("debug read disable", 32'h1, {31'h0, debug_read_disable});
    apb(1'h0, flr_pkg::OFS_STATUS, 32'h0, r, e);
    chk("status at reset", 32'h1, r);
    chk("mapped no error", 32'h0, {31'h0, e});
    apb(1'h0, 12'h010, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    repeat (4) begin
      w = rnd();
      apb(1'h1, flr_pkg::OFS_DIVIDER, w, r, e);
      apb(1'h0, flr_pkg::OFS_DIVIDER, 32'h0, r, e);
      chk("divider reg", {25'h0, w[6:0]}, r);
      chk("divider out", {25'h0, w[6:0]}, {25'h0, erase_timing_divider_value});
    end
    key_try(key, 1'h1);
    apb(1'h1, flr_pkg::OFS_CTRL, 32'h1, r, e);
    key_try(key ^ 32'h00000100, 1'h1);
    key_try(key, 1'h0);
    do_reset(1'h1);
    host.port_reset();
    host.scan(1'h1, 4, {4'h0, flr_pkg::IR_BYPASS}, irc);
    chk("ir capture", 32'h1, {28'h0, irc[3:0]});
    w = rnd();
    host.scan(1'h0, 7, w[7:0], c);
    host.rti_wait(20);
    chk("no erase in bypass", 32'h0, erase_len);
    chk("bypass path", {25'h0, w[5:0], 1'h0}, {25'h0, c[6:0]});
    chk("tdo driven in shift", 32'h1, {31'h0, oe_cnt > 0});
    chk("tdo released idle", 32'h0, {31'h0, tdo_oe});
    apb(1'h1, flr_pkg::OFS_DIVIDER, 32'h15, r, e);
    host.port_reset();
    // At 40 MHz only prescale on with divide 12..15 lands in the erase clock band.
    w = rnd();
    v = {1'h1, 6'h0C + {4'h0, w[1:0]}};
    host.recover(v, irc);
    chk("ir capture recovery", 32'h1, {28'h0, irc[3:0]});
    chk("divider during erase", {25'h0, v}, {25'h0, seen_div});
    chk("erase not short", 32'h1, {31'h0, erase_len >= (ETK - 1) * tick_len(v)});
    chk("erase not long", 32'h1, {31'h0, erase_len <= (ETK + 1) * tick_len(v) + 8});
    chk("erase ended", 32'h0, {31'h0, flash_mass_erase});
    chk("recovery done", 32'h1, {31'h0, recovery_done});
    chk("debug read after erase", 32'h0, {31'h0, debug_read_disable});
    apb(1'h0, flr_pkg::OFS_STATUS, 32'h0, r, e);
    chk("status after erase", 32'h4, r & 32'h7);
    chk("divider restored", 32'h15, {25'h0, erase_timing_divider_value});
    host.port_reset();
    do_reset(1'h0);
    chk("done cleared", 32'h0, {31'h0, recovery_done});
    chk("debug read unsecured", 32'h0, {31'h0, debug_read_disable});
    test_done();
  end
endmodule
`default_nettype wire
